// *** bench/tb_slow_system_timers.sv ***
// Self-checking testbench for the slow system timers block.
`timescale 1ns/1ps
module tb_slow_system_timers;
    import sst_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic calibrated_1k_clock = 1'b0;
    logic low_speed_crystal_clock = 1'b0;
    logic internal_10k_oscillator = 1'b1;
    logic debug_halt = 1'b0;
    logic mac_value_we = 1'b0;
    logic [MAC_W-1:0] mac_value_wdata = '0;
    logic mac_control_we = 1'b0;
    logic [1:0] mac_control_wdata = 2'h0;
    logic [MAC_W-1:0] mac_counter_value;
    logic [1:0] mac_counter_control;
    logic watchdog_key_we = 1'b0;
    logic [15:0] watchdog_key_reg = 16'h0000;
    logic watchdog_control_we = 1'b0;
    logic watchdog_enable_bit = 1'b0;
    logic watchdog_disable_bit = 1'b0;
    logic watchdog_restart_reg = 1'b0;
    logic watchdog_enabled;
    logic [WDG_W-1:0] watchdog_count;
    logic watchdog_nmi;
    logic chip_reset_req;
    logic sleep_cfg_we = 1'b0;
    sst_slp_cfg_t sleep_cfg_wdata = '0;
    sst_cmp_t sleep_cmp = '0;
    sst_slp_cfg_t sleep_timer_config;
    logic [SLP_W-1:0] sleep_count;
    sst_evt_t sleep_events;
    logic tick_use_sleep_clock = 1'b0;
    logic processor_clock_tick = 1'b0;
    logic tick_timer_pulse;
    logic [2:0] seen = 3'h0;
    int mismatches = 0;
    int checked = 0;

    // A 20 ns period gives the 50 MHz system clock.
    always #10 sys_clk = ~sys_clk;

    sst_top u_dut (.sys_clk(sys_clk), .rst(rst), .calibrated_1k_clock(calibrated_1k_clock),
        .low_speed_crystal_clock(low_speed_crystal_clock), .internal_10k_oscillator(internal_10k_oscillator),
        .debug_halt(debug_halt), .mac_value_we(mac_value_we), .mac_value_wdata(mac_value_wdata),
        .mac_control_we(mac_control_we), .mac_control_wdata(mac_control_wdata),
        .mac_counter_value(mac_counter_value), .mac_counter_control(mac_counter_control),
        .watchdog_key_we(watchdog_key_we), .watchdog_key_reg(watchdog_key_reg),
        .watchdog_control_we(watchdog_control_we), .watchdog_enable_bit(watchdog_enable_bit),
        .watchdog_disable_bit(watchdog_disable_bit), .watchdog_restart_reg(watchdog_restart_reg),
        .watchdog_enabled(watchdog_enabled), .watchdog_count(watchdog_count), .watchdog_nmi(watchdog_nmi),
        .chip_reset_req(chip_reset_req), .sleep_cfg_we(sleep_cfg_we), .sleep_cfg_wdata(sleep_cfg_wdata),
        .sleep_cmp(sleep_cmp), .sleep_timer_config(sleep_timer_config), .sleep_count(sleep_count),
        .sleep_events(sleep_events), .tick_use_sleep_clock(tick_use_sleep_clock),
        .processor_clock_tick(processor_clock_tick), .tick_timer_pulse(tick_timer_pulse));

    // Event pulses last one cycle, so they are caught in sticky flags here.
    always @(posedge sys_clk) begin
        if (sleep_events.cmp_a_hit === 1'b1) seen[2] <= 1'b1;
        if (sleep_events.cmp_b_hit === 1'b1) seen[1] <= 1'b1;
        if (sleep_events.wrap === 1'b1) seen[0] <= 1'b1;
    end

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Each write holds its strobe for exactly one sampling edge.
    task automatic key(input logic [15:0] k);
        @(negedge sys_clk);
        watchdog_key_reg = k;
        watchdog_key_we = 1'b1;
        @(negedge sys_clk);
        watchdog_key_we = 1'b0;
    endtask

    task automatic wctl(input logic en, input logic dis);
        @(negedge sys_clk);
        watchdog_enable_bit = en;
        watchdog_disable_bit = dis;
        watchdog_control_we = 1'b1;
        @(negedge sys_clk);
        watchdog_control_we = 1'b0;
    endtask

    task automatic kick();
        @(negedge sys_clk);
        watchdog_restart_reg = 1'b1;
        @(negedge sys_clk);
        watchdog_restart_reg = 1'b0;
    endtask

    task automatic scfg(input logic rev, input logic en, input logic dbg, input logic [3:0] psc, input logic sel);
        @(negedge sys_clk);
        sleep_cfg_wdata = '{rev, en, dbg, psc, sel};
        sleep_cfg_we = 1'b1;
        @(negedge sys_clk);
        sleep_cfg_we = 1'b0;
    endtask

    task automatic mctl(input logic [1:0] c);
        @(negedge sys_clk);
        mac_control_wdata = c;
        mac_control_we = 1'b1;
        @(negedge sys_clk);
        mac_control_we = 1'b0;
    endtask

    // A slow tick is 4 cycles high and 4 low, well above the three-cycle pin delay.
    task automatic tick(input logic xtal, input int n);
        for (int i = 0; i < n; i++) begin
            if (xtal) low_speed_crystal_clock = 1'b1;
            else calibrated_1k_clock = 1'b1;
            repeat (4) @(negedge sys_clk);
            low_speed_crystal_clock = 1'b0;
            calibrated_1k_clock = 1'b0;
            repeat (4) @(negedge sys_clk);
        end
    endtask

    // The limit is over four times the expected run length.
    initial begin
        #1500000;
        mismatches++;
        $display("unexpected timeout: expected end of tests, seen hang");
        final_report();
    end

    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        chk("wdg enabled", 32'h0, 32'(watchdog_enabled));
        chk("cfg", 32'(sst_slp_cfg_t'{1'b0, 1'b0, DEBUG_PAUSE_BIT_RESET, PSC_RESET, 1'b0}), 32'(sleep_timer_config));
        // MAC counter: write, advance six cycles across the 20-bit wrap, then clear.
        @(negedge sys_clk);
        mac_value_wdata = 20'hffffd;
        mac_value_we = 1'b1;
        @(negedge sys_clk);
        mac_value_we = 1'b0;
        chk("mac value", 32'h000ffffd, 32'(mac_counter_value));
        mctl(2'h1);
        repeat (4) @(negedge sys_clk);
        mctl(2'h0);
        chk("mac value", 32'h00000003, 32'(mac_counter_value));
        mctl(2'h2);
        chk("mac control", 32'h2, 32'(mac_counter_control));
        // The stored clear bit acts on the counter one edge after the write.
        @(negedge sys_clk);
        chk("mac value", 32'h0, 32'(mac_counter_value));
        mctl(2'h0);
        // Watchdog key protection: no key, wrong key, then the right one.
        wctl(1'b1, 1'b0);
        chk("wdg enabled", 32'h0, 32'(watchdog_enabled));
        key(16'h1234);
        wctl(1'b1, 1'b0);
        chk("wdg enabled", 32'h0, 32'(watchdog_enabled));
        key(KEY_ENABLE);
        wctl(1'b1, 1'b0);
        chk("wdg enabled", 32'h1, 32'(watchdog_enabled));
        tick(1'b0, 5);
        chk("wdg count", 32'd5, 32'(watchdog_count));
        kick();
        chk("wdg count", 32'd0, 32'(watchdog_count));
        debug_halt = 1'b1;
        tick(1'b0, 3);
        chk("wdg count", 32'd0, 32'(watchdog_count));
        scfg(1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
        tick(1'b0, 3);
        chk("wdg count", 32'd3, 32'(watchdog_count));
        debug_halt = 1'b0;
        internal_10k_oscillator = 1'b0;
        tick(1'b0, 3);
        chk("wdg count", 32'd3, 32'(watchdog_count));
        internal_10k_oscillator = 1'b1;
        kick();
        tick(1'b0, WDG_WARN_MS - 1);
        chk("nmi", 32'h0, 32'(watchdog_nmi));
        tick(1'b0, 1);
        chk("nmi", 32'h1, 32'(watchdog_nmi));
        tick(1'b0, WDG_TIMEOUT_MS - WDG_WARN_MS - 1);
        chk("reset req", 32'h0, 32'(chip_reset_req));
        tick(1'b0, 1);
        chk("reset req", 32'h1, 32'(chip_reset_req));
        chk("wdg count", 32'd2048, 32'(watchdog_count));
        wctl(1'b0, 1'b1);
        chk("wdg enabled", 32'h1, 32'(watchdog_enabled));
        key(KEY_DISABLE);
        wctl(1'b0, 1'b1);
        chk("wdg enabled", 32'h0, 32'(watchdog_enabled));
        // The warning level is registered, so it falls one edge after the disable.
        @(negedge sys_clk);
        chk("nmi", 32'h0, 32'(watchdog_nmi));
        // Sleep timer forward with both compares, then refused writes while running.
        sleep_cmp = '{32'd3, 32'd5};
        scfg(1'b0, 1'b1, 1'b0, 4'h0, 1'b0);
        tick(1'b0, 6);
        chk("sleep count", 32'd6, sleep_count);
        chk("compare flags", 32'h6, 32'(seen));
        scfg(1'b1, 1'b1, 1'b0, 4'h2, 1'b1);
        chk("cfg prescale", 32'h0, 32'(sleep_timer_config.prescale));
        chk("cfg reverse", 32'h0, 32'(sleep_timer_config.reverse));
        debug_halt = 1'b1;
        tick(1'b0, 3);
        chk("sleep count", 32'd6, sleep_count);
        debug_halt = 1'b0;
        internal_10k_oscillator = 1'b0;
        tick(1'b0, 3);
        chk("sleep count", 32'd6, sleep_count);
        internal_10k_oscillator = 1'b1;
        scfg(1'b0, 1'b0, 1'b0, 4'h2, 1'b0);
        scfg(1'b0, 1'b1, 1'b0, 4'h2, 1'b0);
        tick(1'b0, 8);
        chk("sleep count", 32'd8, sleep_count);
        scfg(1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
        scfg(1'b0, 1'b1, 1'b0, 4'h0, 1'b1);
        tick(1'b0, 3);
        chk("sleep count", 32'd8, sleep_count);
        tick(1'b1, 2);
        chk("sleep count", 32'd10, sleep_count);
        // Backward from ten crosses zero and must flag the wrap.
        scfg(1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
        scfg(1'b1, 1'b1, 1'b0, 4'h0, 1'b0);
        seen = 3'h0;
        tick(1'b0, 10);
        chk("wrap flag", 32'h0, 32'(seen[0]));
        tick(1'b0, 1);
        chk("sleep count", 32'hffffffff, sleep_count);
        chk("wrap flag", 32'h1, 32'(seen[0]));
        // Tick timer source choice, with no slow edge in flight.
        processor_clock_tick = 1'b1;
        #1;
        chk("tick pulse", 32'h1, 32'(tick_timer_pulse));
        tick_use_sleep_clock = 1'b1;
        #1;
        chk("tick pulse", 32'h0, 32'(tick_timer_pulse));
        processor_clock_tick = 1'b0;
        final_report();
    end
endmodule

// *** verilog/sst_pkg.sv ***
// Package of constants and carrier types for the slow system timers block.
package sst_pkg;
    // Widths of the counter outputs and of the prescale field.
    localparam int MAC_W = 20;
    localparam int SLP_W = 32;
    localparam int WDG_W = 12;
    localparam int PSC_W = 4;
    // Watchdog figures in milliseconds on the calibrated 1 kHz tick.
    localparam int WDG_TIMEOUT_MS = 2048;
    localparam int WDG_WARN_MS = 1792;
    localparam int TICK_1K_HZ = 1000;
    localparam logic [WDG_W-1:0] WDG_WARN_CNT = WDG_W'(WDG_WARN_MS * TICK_1K_HZ / 1000);
    localparam logic [12:0] WDG_EXPIRE_CNT = 13'(WDG_TIMEOUT_MS * TICK_1K_HZ / 1000);
    // Watchdog key codes.
    localparam logic [15:0] KEY_ENABLE = 16'heabe;
    localparam logic [15:0] KEY_DISABLE = 16'hdead;
    // Reset values.
    localparam logic [MAC_W-1:0] MAC_RESET = 20'h00000;
    localparam logic [SLP_W-1:0] SLP_RESET = 32'h00000000;
    localparam logic [PSC_W-1:0] PSC_RESET = 4'h0;
    localparam logic DEBUG_PAUSE_BIT_RESET = 1'b1;

    // Sleep timer configuration carrier.
    typedef struct packed {
        logic reverse;
        logic enable;
        logic debug_pause_bit;
        logic [PSC_W-1:0] prescale;
        logic sleep_clock_select;
    } sst_slp_cfg_t;

    // Sleep timer compare values carrier.
    typedef struct packed {
        logic [SLP_W-1:0] cmp_a;
        logic [SLP_W-1:0] cmp_b;
    } sst_cmp_t;

    // Sleep timer events carrier.
    typedef struct packed {
        logic cmp_a_hit;
        logic cmp_b_hit;
        logic wrap;
    } sst_evt_t;
endpackage

// *** verilog/sst_prescaler.sv ***
// Power-of-two prescaler turning a source tick into a divided tick.
`timescale 1ns/1ps
module sst_prescaler #(
    parameter int PSC_W = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Control.
    input wire logic run,
    input wire logic clear,
    input wire logic [PSC_W-1:0] exponent,
    input wire logic src_tick,
    // Result.
    output logic div_tick
);
    localparam int DIV_W = 1 << PSC_W;
    initial begin
        if (PSC_W < 1 || PSC_W > 5) begin
            $error("sst_prescaler: PSC_W out of range");
        end
    end

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] mask;
    logic [DIV_W-1:0] one_w;

    assign one_w = {{(DIV_W-1){1'b0}}, 1'b1};
    // Mask of the low exponent bits; the tick fires when they are all ones.
    assign mask = (one_w << exponent) - one_w;
    assign div_tick = run && src_tick && ((div_reg & mask) == mask);

    // Divider count advances on each source tick while running.
    always_ff @(posedge sys_clk) begin
        if (rst || clear) begin
            div_reg <= '0;
        end else if (run && src_tick) begin
            div_reg <= div_reg + one_w;
        end
    end
endmodule

// *** verilog/sst_top.sv ***
// Slow system timers: MAC counter, watchdog and sleep timer.
`timescale 1ns/1ps
// Behaviour
// - A 20-bit MAC counter, readable and writable by software.
// - MAC control has an advance-enable bit and a counter-clear bit.
// - Watchdog comes up disabled after power-up reset.
// - Watchdog counts 1 kHz ticks and expires at 2.048 s unrestarted.
// - At 1.792 s count the watchdog raises an early-warning NMI.
// - Watchdog stops during debug halt only when debug-pause bit is set.
// - Watchdog holds its count while the 1 kHz clock is stopped.
// - Enable bit is accepted only after key 0xEABE was written.
// - Disable bit is accepted only after key 0xDEAD was written.
// - A 32-bit sleep timer for timing and programmed wake-up.
// - Sleep clock is 1 kHz or 32 kHz by select bit, 1 kHz after reset.
// - Sleep source passes a prescaler dividing by two to a programmable power.
// - Two compares and a wrap flag, each may raise interrupt or wake.
// - Sleep timer pauses during debug halt without any configuration bit.
// - With 10 kHz oscillator and crystal both off, sleep timer stops, no wakes.
// - Tick timer clock chosen between processor clock and sleep timer clock.
// - Direction, prescaler and clock select change only while sleep timer disabled.
// - Any kick write restarts the watchdog count from zero.
module sst_top
    import sst_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Raw low-speed clock pins and the debug halt input, sampled here.
    input wire logic calibrated_1k_clock,
    input wire logic low_speed_crystal_clock,
    input wire logic internal_10k_oscillator,
    input wire logic debug_halt,
    // MAC counter access.
    input wire logic mac_value_we,
    input wire logic [sst_pkg::MAC_W-1:0] mac_value_wdata,
    input wire logic mac_control_we,
    input wire logic [1:0] mac_control_wdata,
    output logic [sst_pkg::MAC_W-1:0] mac_counter_value,
    output logic [1:0] mac_counter_control,
    // Watchdog access.
    input wire logic watchdog_key_we,
    input wire logic [15:0] watchdog_key_reg,
    input wire logic watchdog_control_we,
    input wire logic watchdog_enable_bit,
    input wire logic watchdog_disable_bit,
    input wire logic watchdog_restart_reg,
    output logic watchdog_enabled,
    output logic [sst_pkg::WDG_W-1:0] watchdog_count,
    output logic watchdog_nmi,
    output logic chip_reset_req,
    // Sleep timer access.
    input wire logic sleep_cfg_we,
    input wire sst_pkg::sst_slp_cfg_t sleep_cfg_wdata,
    input wire sst_pkg::sst_cmp_t sleep_cmp,
    output sst_pkg::sst_slp_cfg_t sleep_timer_config,
    output logic [sst_pkg::SLP_W-1:0] sleep_count,
    output sst_pkg::sst_evt_t sleep_events,
    // Tick timer clock choice.
    input wire logic tick_use_sleep_clock,
    input wire logic processor_clock_tick,
    output logic tick_timer_pulse
);
    import sst_pkg::*;

    // Two-flop synchronisers for the pin inputs.
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic k1_prev_reg;
    logic k32_prev_reg;
    logic osc_on;
    logic halted;
    logic tick_1k;
    logic tick_32k;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {debug_halt, internal_10k_oscillator, low_speed_crystal_clock, calibrated_1k_clock};
            sync2_reg <= sync1_reg;
        end
    end

    // Rising edge detection on the synchronised slow clocks.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            k1_prev_reg <= 1'b0;
            k32_prev_reg <= 1'b0;
        end else begin
            k1_prev_reg <= sync2_reg[0];
            k32_prev_reg <= sync2_reg[1];
        end
    end

    assign osc_on = sync2_reg[2];
    assign halted = sync2_reg[3];
    // 1 kHz stops without oscillator.
    // A dead 10 kHz oscillator means no 1 kHz edges are honoured, even if the pin glitches.
    assign tick_1k = sync2_reg[0] && !k1_prev_reg && osc_on;
    assign tick_32k = sync2_reg[1] && !k32_prev_reg;

    // ---------------- MAC counter ----------------
    logic [MAC_W-1:0] mac_reg;
    logic mac_en_reg;
    logic mac_clr_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mac_en_reg <= 1'b0;
            mac_clr_reg <= 1'b0;
        end else if (mac_control_we) begin
            mac_en_reg <= mac_control_wdata[0];
            mac_clr_reg <= mac_control_wdata[1];
        end
    end

    // MAC counter update.
    // The counter advances on the system clock; clear holds it at zero while set.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mac_reg <= MAC_RESET;
        end else if (mac_clr_reg) begin
            mac_reg <= MAC_RESET;
        end else if (mac_value_we) begin
            mac_reg <= mac_value_wdata;
        end else if (mac_en_reg) begin
            mac_reg <= mac_reg + 20'h00001;
        end
    end

    assign mac_counter_value = mac_reg;
    assign mac_counter_control = {mac_clr_reg, mac_en_reg};

    // ---------------- Watchdog ----------------
    typedef enum logic [1:0] {
        SST_KEY_NONE,
        SST_KEY_EN,
        SST_KEY_DIS
    } sst_key_t;

    sst_key_t key_reg;
    logic wdg_en_reg;
    logic [12:0] wdg_cnt_reg;
    logic nmi_reg;
    logic rst_req_reg;
    logic wdg_step;

    // Armed key; a control write consumes it unless a key write in the same cycle wins, so each change needs a new key.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            key_reg <= SST_KEY_NONE;
        end else if (watchdog_key_we) begin
            if (watchdog_key_reg == KEY_ENABLE) begin
                key_reg <= SST_KEY_EN;
            end else if (watchdog_key_reg == KEY_DISABLE) begin
                key_reg <= SST_KEY_DIS;
            end else begin
                key_reg <= SST_KEY_NONE;
            end
        end else if (watchdog_control_we) begin
            key_reg <= SST_KEY_NONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdg_en_reg <= 1'b0;
        end else if (watchdog_control_we) begin
            if (key_reg == SST_KEY_EN && watchdog_enable_bit) begin
                wdg_en_reg <= 1'b1;
            end else if (key_reg == SST_KEY_DIS && watchdog_disable_bit) begin
                wdg_en_reg <= 1'b0;
            end
        end
    end

    assign wdg_step = wdg_en_reg && tick_1k && !(halted && sleep_timer_config.debug_pause_bit);

    // Watchdog count on 1 kHz ticks.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdg_cnt_reg <= 13'h0000;
        end else if (watchdog_restart_reg || !wdg_en_reg) begin
            wdg_cnt_reg <= 13'h0000;
        end else if (wdg_step && wdg_cnt_reg != WDG_EXPIRE_CNT) begin
            wdg_cnt_reg <= wdg_cnt_reg + 13'h0001;
        end
    end

    // Early warning level.
    // The warning stays high until a kick or a disable, so the handler cannot miss it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nmi_reg <= 1'b0;
        end else begin
            nmi_reg <= wdg_en_reg && (wdg_cnt_reg >= {1'b0, WDG_WARN_CNT});
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rst_req_reg <= 1'b0;
        end else begin
            rst_req_reg <= wdg_en_reg && (wdg_cnt_reg == WDG_EXPIRE_CNT);
        end
    end

    assign watchdog_enabled = wdg_en_reg;
    assign watchdog_count = wdg_cnt_reg[WDG_W-1:0];
    assign watchdog_nmi = nmi_reg;
    assign chip_reset_req = rst_req_reg;

    // ---------------- Sleep timer ----------------
    sst_slp_cfg_t cfg_reg;
    logic [SLP_W-1:0] slp_reg;
    sst_evt_t evt_reg;
    logic src_tick;
    logic src_alive;
    logic slp_run;
    logic slp_tick;
    logic [SLP_W-1:0] slp_next;

    // Locked fields while enabled.
    // Enable and debug pause are always writable; the rest only with enable clear.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_reg.reverse <= 1'b0;
            cfg_reg.enable <= 1'b0;
            cfg_reg.debug_pause_bit <= DEBUG_PAUSE_BIT_RESET;
            cfg_reg.prescale <= PSC_RESET;
            cfg_reg.sleep_clock_select <= 1'b0;
        end else if (sleep_cfg_we) begin
            cfg_reg.enable <= sleep_cfg_wdata.enable;
            cfg_reg.debug_pause_bit <= sleep_cfg_wdata.debug_pause_bit;
            if (!cfg_reg.enable) begin
                cfg_reg.reverse <= sleep_cfg_wdata.reverse;
                cfg_reg.prescale <= sleep_cfg_wdata.prescale;
                cfg_reg.sleep_clock_select <= sleep_cfg_wdata.sleep_clock_select;
            end
        end
    end

    assign sleep_timer_config = cfg_reg;
    assign src_tick = cfg_reg.sleep_clock_select ? tick_32k : tick_1k;
    assign src_alive = cfg_reg.sleep_clock_select || osc_on;
    assign slp_run = cfg_reg.enable && !halted && src_alive;

    sst_prescaler #(
        .PSC_W(PSC_W)
    ) u_psc (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(slp_run),
        .clear(!cfg_reg.enable),
        .exponent(cfg_reg.prescale),
        .src_tick(src_tick),
        .div_tick(slp_tick)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slp_reg <= SLP_RESET;
        end else if (slp_tick) begin
            slp_reg <= cfg_reg.reverse ? slp_reg - 32'h00000001 : slp_reg + 32'h00000001;
        end
    end

    // Compare and wrap events.
    // Events are one-cycle pulses on the count step; a stopped timer raises none.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_reg <= '0;
        end else begin
            evt_reg.cmp_a_hit <= slp_tick && (slp_next == sleep_cmp.cmp_a);
            evt_reg.cmp_b_hit <= slp_tick && (slp_next == sleep_cmp.cmp_b);
            evt_reg.wrap <= slp_tick && (cfg_reg.reverse ? slp_reg == 32'h00000000 : slp_reg == 32'hffffffff);
        end
    end

    assign slp_next = cfg_reg.reverse ? slp_reg - 32'h00000001 : slp_reg + 32'h00000001;
    assign sleep_count = slp_reg;
    assign sleep_events = evt_reg;

    assign tick_timer_pulse = tick_use_sleep_clock ? slp_tick : processor_clock_tick;

    // ---------------- Assertions ----------------
    // Enable without the key never takes effect.
    keyed_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!wdg_en_reg && watchdog_control_we && key_reg != SST_KEY_EN) |=> !wdg_en_reg)
        else $error("watchdog enabled without key");
    keyed_disable_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wdg_en_reg && watchdog_control_we && !watchdog_key_we && key_reg != SST_KEY_DIS) |=> wdg_en_reg)
        else $error("watchdog disabled without key");
    kick_restart_a: assert property (@(posedge sys_clk) disable iff (rst)
        watchdog_restart_reg |=> (wdg_cnt_reg == 13'h0000) ##1 !nmi_reg)
        else $error("kick did not restart watchdog");
    warn_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wdg_en_reg && wdg_cnt_reg == {1'b0, WDG_WARN_CNT} && !watchdog_control_we) |=> nmi_reg)
        else $error("early warning missing at low water mark");
    expire_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(rst_req_reg) |-> $past(wdg_cnt_reg) == WDG_EXPIRE_CNT)
        else $error("reset request without full timeout");
    debug_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (halted && cfg_reg.debug_pause_bit && !watchdog_restart_reg && wdg_en_reg) |=> $stable(wdg_cnt_reg))
        else $error("watchdog counted during debug pause");
    sleep_halt_a: assert property (@(posedge sys_clk) disable iff (rst)
        halted |=> $stable(slp_reg))
        else $error("sleep timer counted while halted");
    cfg_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_reg.enable |=> $stable(cfg_reg.prescale) && $stable(cfg_reg.sleep_clock_select))
        else $error("locked sleep config changed");
    dead_source_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!osc_on && !cfg_reg.sleep_clock_select) |=> !evt_reg.cmp_a_hit && !evt_reg.cmp_b_hit)
        else $error("wake event with dead source");
endmodule
